// File: design/cfg_pkg.sv
/*
  Constants for the transmit, clock output and packet configuration bank:
  register indices, field positions, reset values and filter codes.
  Assumes a host that writes one 8-bit register per transfer.
*/
// ==========================================================================
package cfg_pkg;
  localparam logic [7:0] ADDR_TX = 8'h1a;
  localparam logic [7:0] ADDR_OSC = 8'h1b;
  localparam logic [7:0] ADDR_PLEN = 8'h1c;
  localparam logic [7:0] ADDR_NODE = 8'h1d;
  localparam logic [7:0] ADDR_PFMT = 8'h1e;
  localparam logic [7:0] ADDR_FIFO = 8'h1f;
  // Reset values
  localparam logic [7:0] RST_TX = 8'h72;
  localparam logic [7:0] RST_OSC = 8'hbc;
  localparam logic [7:0] RST_PLEN = 8'h00;
  localparam logic [7:0] RST_NODE = 8'h00;
  localparam logic [7:0] RST_PFMT = 8'h48;
  localparam logic [7:0] RST_FIFO = 8'h00;
  // Writable masks; reserved and status bits are not stored
  localparam logic [7:0] MASK_OSC = 8'hfc;
  localparam logic [7:0] MASK_PFMT = 8'hfe;
  localparam logic [7:0] MASK_FIFO = 8'hc0;
  localparam logic [7:0] BCAST_LO = 8'h00;
  localparam logic [7:0] BCAST_HI = 8'hff;
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_NODE = 2'h1;
  localparam logic [1:0] FILT_ZERO = 2'h2;
  localparam logic [4:0] DIV_BYPASS = 5'h00;
  localparam int DIV_WIDTH = 5;
  // Field positions inside each register
  localparam int TX_CUT_LSB = 4;
  localparam int TX_PWR_LSB = 1;
  localparam int TX_ZIF_BIT = 0;
  localparam int OSC_EN_BIT = 7;
  localparam int OSC_DIV_LSB = 2;
  localparam int PLEN_MAN_BIT = 7;
  localparam int PLEN_LEN_LSB = 0;
  localparam int PFMT_VAR_BIT = 7;
  localparam int PFMT_PRE_LSB = 5;
  localparam int PFMT_WHT_BIT = 4;
  localparam int PFMT_CRC_BIT = 3;
  localparam int PFMT_FILT_LSB = 1;
  localparam int PFMT_STAT_BIT = 0;
  localparam int FIFO_ACLR_BIT = 7;
  localparam int FIFO_STBY_BIT = 6;
  // Preamble byte count is the code plus this base
  localparam logic [2:0] PRE_BASE = 3'h1;
endpackage : cfg_pkg

// File: design/clkout_div.sv
/*
  Reference clock output divider. Produces the divided output as a
  registered level on clk_sys, where clk_sys stands for the crystal.
  Assumes the divider setting changes only rarely; a change restarts it.
*/
module clkout_div #(
  parameter int DIV_W = 5
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic [DIV_W-1:0] div,
  output logic clk_out
);
  // A zero-width divider field cannot select any rate
  if (DIV_W < 1)
  begin : g_div_w_check
    $error("DIV_W must be positive");
  end

  // ==========================================================================
  // Divider: half period of div cycles gives fxtal/(2*div)
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic out_q, out_d;
  logic [DIV_W-1:0] div_q;

  always_comb
  begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!enable)
    begin
      cnt_d = '0;
      out_d = 1'b0;
    end
    else if (div != div_q)
    begin
      cnt_d = '0;
    end
    else if (div == cfg_pkg::DIV_BYPASS)
    begin
      out_d = 1'b1; // Bypass: gated below by clk_sys itself is avoided
    end
    else if (cnt_q == div - DIV_W'(1))
    begin
      cnt_d = '0;
      out_d = ~out_q;
    end
    else
    begin
      cnt_d = cnt_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= '0;
      out_q <= 1'b0;
      div_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_q <= out_d;
      div_q <= div;
    end
  end

  // Bypass shows a steady level: a flop cannot toggle at its own clock rate
  assign clk_out = out_q;
endmodule : clkout_div

// File: design/tx_clkout_packet_config_regs.sv
/*
  Configuration bank for transmit, clock output and packet handling.
  Assumes a serial port front end that presents one decoded 8-bit
  register write or read strobe per transfer, and a packet engine that
  reports received address bytes and CRC results as pulses.
  Limitation: a divider setting of zero holds the clock output high,
  since a flop on clk_sys cannot toggle at the reference rate itself.
*/
module tx_clkout_packet_config_regs (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic crc_done,
  input wire logic crc_pass,
  input wire logic addr_valid,
  input wire logic [7:0] rx_addr,
  output logic addr_accept,
  output logic fifo_clear,
  output logic [3:0] tx_interp_cutoff,
  output logic [2:0] tx_power,
  output logic tx_zero_if,
  output logic clk_out,
  output logic var_length,
  output logic [6:0] payload_length,
  output logic manchester_en,
  output logic [7:0] node_address,
  output logic [2:0] preamble_bytes,
  output logic whitening_en,
  output logic crc_en,
  output logic [1:0] addr_filter,
  output logic fifo_autoclr_off,
  output logic fifo_stby_read
);
  // ==========================================================================
  // Register storage
  logic [7:0] tx_q, tx_d, osc_q, osc_d, plen_q, plen_d;
  logic [7:0] node_q, node_d, pfmt_q, pfmt_d, fifo_q, fifo_d;
  logic crc_ok_q, crc_ok_d;

  // Each transfer writes at most one register, reserved bits masked off
  always_comb
  begin
    tx_d = tx_q;
    osc_d = osc_q;
    plen_d = plen_q;
    node_d = node_q;
    pfmt_d = pfmt_q;
    fifo_d = fifo_q;
    if (wr_en)
    begin
      // Unmapped addresses leave every register untouched
      case (addr)
        cfg_pkg::ADDR_TX: tx_d = wdata;
        cfg_pkg::ADDR_OSC: osc_d = wdata & cfg_pkg::MASK_OSC;
        cfg_pkg::ADDR_PLEN: plen_d = wdata;
        cfg_pkg::ADDR_NODE: node_d = wdata;
        cfg_pkg::ADDR_PFMT: pfmt_d = wdata & cfg_pkg::MASK_PFMT;
        cfg_pkg::ADDR_FIFO: fifo_d = wdata & cfg_pkg::MASK_FIFO;
        default: ;
      endcase
    end
  end

  // CRC status follows the latest checked packet; writes cannot touch it
  always_comb
  begin
    crc_ok_d = crc_ok_q;
    if (crc_done)
    begin
      crc_ok_d = crc_pass;
    end
  end

  // Registers load their power-up values; CRC status starts as fail
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_q <= cfg_pkg::RST_TX;
      osc_q <= cfg_pkg::RST_OSC;
      plen_q <= cfg_pkg::RST_PLEN;
      node_q <= cfg_pkg::RST_NODE;
      pfmt_q <= cfg_pkg::RST_PFMT;
      fifo_q <= cfg_pkg::RST_FIFO;
      crc_ok_q <= 1'b0;
    end
    else
    begin
      tx_q <= tx_d;
      osc_q <= osc_d;
      plen_q <= plen_d;
      node_q <= node_d;
      pfmt_q <= pfmt_d;
      fifo_q <= fifo_d;
      crc_ok_q <= crc_ok_d;
    end
  end

  // ==========================================================================
  // Read port: one cycle after rd_en, unmapped reads return zero
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q;

  // Data holds between reads so a slow host can still pick it up
  always_comb
  begin
    rdata_d = rdata_q;
    if (rd_en)
    begin
      case (addr)
        cfg_pkg::ADDR_TX: rdata_d = tx_q;
        cfg_pkg::ADDR_OSC: rdata_d = osc_q;
        cfg_pkg::ADDR_PLEN: rdata_d = plen_q;
        cfg_pkg::ADDR_NODE: rdata_d = node_q;
        cfg_pkg::ADDR_PFMT:
        begin
          rdata_d = pfmt_q;
          rdata_d[cfg_pkg::PFMT_STAT_BIT] = crc_ok_q;
        end
        cfg_pkg::ADDR_FIFO: rdata_d = fifo_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Answer register; rvalid marks the single cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rd_en;
    end
  end

  // Read answer leaves straight from flops
  assign rdata = rdata_q;
  assign rvalid = rvalid_q;

  // ==========================================================================
  // Field decode towards the transmitter and packet engine
  assign tx_interp_cutoff = tx_q[cfg_pkg::TX_CUT_LSB +: 4];
  assign tx_power = tx_q[cfg_pkg::TX_PWR_LSB +: 3];
  assign tx_zero_if = tx_q[cfg_pkg::TX_ZIF_BIT];
  assign manchester_en = plen_q[cfg_pkg::PLEN_MAN_BIT];
  assign payload_length = plen_q[cfg_pkg::PLEN_LEN_LSB +: 7];
  assign node_address = node_q;
  assign var_length = pfmt_q[cfg_pkg::PFMT_VAR_BIT];
  // Preamble code counts bytes less one, so the sum never wraps
  assign preamble_bytes =
    {1'b0, pfmt_q[cfg_pkg::PFMT_PRE_LSB +: 2]} + cfg_pkg::PRE_BASE;
  assign whitening_en = pfmt_q[cfg_pkg::PFMT_WHT_BIT];
  assign crc_en = pfmt_q[cfg_pkg::PFMT_CRC_BIT];
  assign addr_filter = pfmt_q[cfg_pkg::PFMT_FILT_LSB +: 2];
  assign fifo_autoclr_off = fifo_q[cfg_pkg::FIFO_ACLR_BIT];
  assign fifo_stby_read = fifo_q[cfg_pkg::FIFO_STBY_BIT];

  // ==========================================================================
  // Address filter and CRC driven FIFO clear, registered one-cycle pulses
  logic accept_q, accept_d;
  logic clr_q, clr_d;
  logic hit_node, hit_zero, hit_ones;

  // Compare the received byte against node and both broadcast values
  assign hit_node = (rx_addr == node_q);
  assign hit_zero = (rx_addr == cfg_pkg::BCAST_LO);
  assign hit_ones = (rx_addr == cfg_pkg::BCAST_HI);

  always_comb
  begin
    accept_d = 1'b0;
    if (addr_valid)
    begin
      case (pfmt_q[cfg_pkg::PFMT_FILT_LSB +: 2])
        cfg_pkg::FILT_OFF: accept_d = 1'b1;
        cfg_pkg::FILT_NODE: accept_d = hit_node;
        cfg_pkg::FILT_ZERO: accept_d = hit_node | hit_zero;
        default: accept_d = hit_node | hit_zero | hit_ones;
      endcase
    end
    // Clear only when CRC is in use; a disabled CRC cannot fail a packet
    clr_d = crc_done & ~crc_pass & pfmt_q[cfg_pkg::PFMT_CRC_BIT]
      & ~fifo_q[cfg_pkg::FIFO_ACLR_BIT];
  end

  // Both answers leave a cycle late but glitch free from flops
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      accept_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      accept_q <= accept_d;
      clr_q <= clr_d;
    end
  end

  // Packet-side pulses stand for exactly one cycle
  assign addr_accept = accept_q;
  assign fifo_clear = clr_q;

  // ==========================================================================
  // Reference clock output
  // Divider sits apart so its counter restarts cleanly on each new setting
  clkout_div #(
    .DIV_W(cfg_pkg::DIV_WIDTH)
  ) u_clkout_div (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .enable(osc_q[cfg_pkg::OSC_EN_BIT]),
    .div(osc_q[cfg_pkg::OSC_DIV_LSB +: cfg_pkg::DIV_WIDTH]),
    .clk_out(clk_out)
  );
endmodule : tx_clkout_packet_config_regs

// File: tb/cfg_host.sv
/*
  Host model on the register strobes: one 8-bit transfer at a time.
  Assumes the bench calls wr and rd only after reset is released.
*/
// ==========================================================
// Host
module cfg_host (
  input wire logic clk_sys,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {wr_en, rd_en, addr, wdata} = '0;
  // Strobe lives one edge; a gap edge keeps drivers race free
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 {wr_en, addr, wdata} = {1'b1, a, d};
    @(posedge clk_sys);
    #1 {wr_en, wdata} = {1'b0, ~d};
  endtask : wr
  // Answer is fixed one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    @(posedge clk_sys);
    #1 {rd_en, addr} = {1'b1, a};
    @(posedge clk_sys);
    #1 rd_en = 1'b0;
    ok = rvalid;
    d = rdata;
  endtask : rd
endmodule : cfg_host

// File: tb/tx_clkout_packet_config_regs_sva.sv
/*
  Checker on the bank's ports: read answer and packet-side pulses.
  Assumes one clock and the asynchronous active-low reset.
*/
// ==========================================================
// Checker
module tx_clkout_packet_config_regs_sva (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic rd_en,
  input wire logic rvalid,
  input wire logic crc_done,
  input wire logic crc_pass,
  input wire logic addr_valid,
  input wire logic [7:0] rx_addr,
  input wire logic addr_accept,
  input wire logic fifo_clear,
  input wire logic [7:0] node_address,
  input wire logic [2:0] preamble_bytes,
  input wire logic crc_en,
  input wire logic [1:0] addr_filter,
  input wire logic fifo_autoclr_off
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Failed check that must empty the FIFO
  sequence s_fail;
    crc_done && !crc_pass && crc_en && !fifo_autoclr_off;
  endsequence
  property p_rv; rd_en |=> rvalid; endproperty
  a_rv: assert property (p_rv) else $error("rvalid missing");
  property p_rv_src; rvalid |-> $past(rd_en); endproperty
  a_rv_src: assert property (p_rv_src) else $error("rvalid stray");
  property p_pre; preamble_bytes inside {[3'h1:3'h4]}; endproperty
  a_pre: assert property (p_pre) else $error("preamble count");
  property p_all; addr_valid && addr_filter == 2'h0 |=> addr_accept;
  endproperty
  a_all: assert property (p_all) else $error("open filter");
  property p_node; addr_valid && rx_addr == node_address |=> addr_accept;
  endproperty
  a_node: assert property (p_node) else $error("node dropped");
  property p_rej;
    addr_valid && addr_filter == 2'h1 && rx_addr != node_address
      |=> !addr_accept;
  endproperty
  a_rej: assert property (p_rej) else $error("foreign taken");
  property p_clr; s_fail |=> fifo_clear; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_clr_src; fifo_clear |-> $past(crc_done && !crc_pass);
  endproperty
  a_clr_src: assert property (p_clr_src) else $error("stray clear");
  property p_acc_src; addr_accept |-> $past(addr_valid); endproperty
  a_acc_src: assert property (p_acc_src) else $error("stray acc");
  property p_clr_off; crc_done && fifo_autoclr_off |=> !fifo_clear;
  endproperty
  a_clr_off: assert property (p_clr_off) else $error("clear kept");
endmodule : tx_clkout_packet_config_regs_sva
bind tx_clkout_packet_config_regs tx_clkout_packet_config_regs_sva u_sva (
  .clk_sys(clk_sys), .arst_n(arst_n), .rd_en(rd_en), .rvalid(rvalid),
  .crc_done(crc_done), .crc_pass(crc_pass), .addr_valid(addr_valid),
  .rx_addr(rx_addr), .addr_accept(addr_accept), .fifo_clear(fifo_clear),
  .node_address(node_address), .preamble_bytes(preamble_bytes),
  .crc_en(crc_en), .addr_filter(addr_filter),
  .fifo_autoclr_off(fifo_autoclr_off));

// File: tb/tx_clkout_packet_config_regs_tb_top.sv
/*
  Bench: resets, random register traffic, filter, CRC and clock output.
  Assumes the host model drives the register strobes.
*/
// ==========================================================
// Bench
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tx_clkout_packet_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, arst_n = 0, wr_en, rd_en, rvalid, crc_done = 0;
  logic crc_pass = 0, addr_valid = 0, addr_accept, fifo_clear, tz, ck;
  logic ve, me, we, ce, ao, sr, ok, c0;
  logic [7:0] addr, wdata, rdata, rx_addr = 0, na, d, r, ra;
  logic [3:0] ic;
  logic [2:0] tp, pb;
  logic [6:0] pl;
  logic [1:0] af;
  logic [31:0] seed = 32'h545a;
  int err_count = 0, n_compared = 0, t;
  always #5 clk_sys = ~clk_sys;
  cfg_host host (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
  tx_clkout_packet_config_regs dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid), .crc_done(crc_done),
    .crc_pass(crc_pass), .addr_valid(addr_valid), .rx_addr(rx_addr),
    .addr_accept(addr_accept), .fifo_clear(fifo_clear),
    .tx_interp_cutoff(ic), .tx_power(tp), .tx_zero_if(tz), .clk_out(ck),
    .var_length(ve), .payload_length(pl), .manchester_en(me),
    .node_address(na), .preamble_bytes(pb), .whitening_en(we),
    .crc_en(ce), .addr_filter(af), .fifo_autoclr_off(ao),
    .fifo_stby_read(sr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Stored bits per register; status and reserved bits excluded
  function automatic logic [7:0] wm(input logic [7:0] a);
    case (a)
      cfg_pkg::ADDR_OSC: return cfg_pkg::MASK_OSC;
      cfg_pkg::ADDR_PFMT: return cfg_pkg::MASK_PFMT;
      cfg_pkg::ADDR_FIFO: return cfg_pkg::MASK_FIFO;
      default: return 8'hff;
    endcase
  endfunction : wm
  function automatic logic acc(input int f, input logic [7:0] x);
    return f == 0 || x == 8'h5a || (f >= 2 && x == 8'h00)
      || (f == 3 && x == 8'hff);
  endfunction : acc
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
    input logic [7:0] m);
    host.rd(a, r, ok);
    `CHK(ok, 1'b1)
    `CHK(r & m, e & m)
  endtask : rdc
  task automatic pkt(input logic av, input logic [7:0] x,
    input logic cd, input logic cp);
    @(posedge clk_sys);
    #1 {addr_valid, rx_addr, crc_done, crc_pass} = {av, x, cd, cp};
    @(posedge clk_sys);
    #1 {addr_valid, crc_done} = 2'b00;
  endtask : pkt
  initial
  begin
    #400000;
    $display("mismatch %0t timeout", $time);
    err_count++;
    finish_test();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    // Reset values, then an unmapped read
    rdc(8'h1a, cfg_pkg::RST_TX, 8'hff);
    rdc(8'h1b, cfg_pkg::RST_OSC, 8'hff);
    rdc(8'h1c, cfg_pkg::RST_PLEN, 8'hff);
    rdc(8'h1d, cfg_pkg::RST_NODE, 8'hff);
    rdc(8'h1e, cfg_pkg::RST_PFMT, 8'hff);
    rdc(8'h1f, cfg_pkg::RST_FIFO, 8'hff);
    rdc(8'h20, 8'h00, 8'hff);
    // Random writes; reserved bits sent as zero, status bit sent as one
    for (int i = 0; i < 36; i++)
    begin
      addr_valid = 0;
      t = rnd() % 6;
      ra = 8'h1a + 8'(t);
      d = 8'(rnd());
      if (t != 4)
        d &= wm(ra);
      else
        d[0] = 1'b1;
      host.wr(ra, d);
      rdc(ra, d, wm(ra));
      if (t == 4)
        rdc(ra, 8'h00, 8'h01);
      case (t)
        0: `CHK({ic, tp, tz}, d)
        1: `CHK(ck, !d[7] ? 1'b0 : d[6:2] == 5'h00 ? 1'b1 : ck)
        2: `CHK({me, pl}, d)
        3: `CHK(na, d)
        4: `CHK({ve, pb, we, ce, af}, {d[7], d[6:5] + 3'h1, d[4:1]})
        default: `CHK({ao, sr}, d[7:6])
      endcase
    end
    // Address filter codes against node, both broadcasts and a stranger
    host.wr(8'h1d, 8'h5a);
    for (int f = 0; f < 4; f++)
    begin
      host.wr(8'h1e, 8'h08 | 8'(f << 1));
      for (int j = 0; j < 4; j++)
      begin
        pkt(1'b1, j == 0 ? 8'h5a : j == 1 ? 8'h00 : j == 2 ? 8'hff : 8'h13,
          1'b0, 1'b0);
        `CHK(addr_accept, acc(f, rx_addr))
      end
    end
    // CRC outcome against auto-clear setting
    for (int k = 0; k < 4; k++)
    begin
      host.wr(8'h1f, {k[0], 7'h00});
      pkt(1'b0, 8'h00, 1'b1, k[1]);
      `CHK(fifo_clear, !k[0] && !k[1])
      rdc(8'h1e, {7'h00, k[1]}, 8'h01);
    end
    // Clock output: off, bypass, then divide by 2N
    host.wr(8'h1b, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(ck, 1'b0)
    host.wr(8'h1b, 8'h80);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(ck, 1'b1)
    for (int n = 1; n < 3; n++)
    begin
      host.wr(8'h1b, 8'h80 | 8'(n << 2));
      repeat (4) @(posedge clk_sys);
      #1;
      t = 0;
      for (int c = 0; c < 8; c++)
      begin
        c0 = ck;
        @(posedge clk_sys);
        #1 t += (ck !== c0);
      end
      `CHK(t, 8 / n)
    end
    finish_test();
  end
endmodule : tx_clkout_packet_config_regs_tb_top
